/* File: verification/vvpr_host.sv */
// Purpose: two-wire bus host stand-in driving the register strobes
// Assumes: one strobe per byte, each held for one clock
// Notes: released data lines carry the inverse so stale values never match
`timescale 1ns/1ps
module vvpr_host (
  // clock
  input  wire logic       clk,
  // strobes to the register bank
  output logic            ptrLoad,
  output logic      [7:0] ptrValue,
  output logic            wrByte,
  output logic      [7:0] wrData,
  output logic            rdByteDone,
  // read path
  input  wire logic [7:0] rdData
);
  initial begin
    {ptrLoad, wrByte, rdByteDone} = 3'h0;
    {ptrValue, wrData} = 16'h0;
  end
  task automatic ptr(input logic [7:0] v);
    @(posedge clk) {ptrLoad, ptrValue} <= {1'h1, v};
    @(posedge clk) {ptrLoad, ptrValue} <= {1'h0, ~v};
  endtask
  task automatic wr(input logic [7:0] v);
    @(posedge clk) {wrByte, wrData} <= {1'h1, v};
    @(posedge clk) {wrByte, wrData} <= {1'h0, ~v};
  endtask
  task automatic rd(output logic [7:0] v);
    #1 v = rdData;
    @(posedge clk) rdByteDone <= 1'h1;
    @(posedge clk) rdByteDone <= 1'h0;
  endtask
endmodule // vvpr_host

/* File: verification/vvpr_regs_tb.sv */
// Purpose: self-checking bench for the voltage profile register bank
// Assumes: host stand-in supplies all bus strobes
// Notes: clkEn drops at random in one scenario to check freezing
`timescale 1ns/1ps
module vvpr_regs_tb;
  logic clk, reset_n, clkEn, logicSupplyUvlo, mainSupplyUvlo;
  logic selHi, selLo, extClk, ptrLoad, wrByte, rdByteDone;
  logic forcedPwm, extClkFollow, syncLocked;
  logic [7:0] ptrValue, wrData, rdData, regPointer, pOne, pTwo;
  logic [5:0] voutCode;
  logic [10:0] voutMv;
  logic [7:0] junk;
  logic en;
  int n_errors, num_checks, nEn;
  vvpr_regs i_dut (.clk(clk), .reset_n(reset_n), .clkEn(clkEn),
    .logicSupplyUvlo(logicSupplyUvlo), .mainSupplyUvlo(mainSupplyUvlo),
    .ptrLoad(ptrLoad), .ptrValue(ptrValue), .wrByte(wrByte), .wrData(wrData),
    .rdByteDone(rdByteDone), .rdData(rdData), .regPointer(regPointer),
    .profile_sel_hi_pin(selHi), .profile_sel_lo_pin(selLo), .extClkPresent(extClk),
    .forcedPwm(forcedPwm), .extClkFollow(extClkFollow), .syncLocked(syncLocked),
    .voutCode(voutCode), .voutMv(voutMv));
  vvpr_host i_host (.clk(clk), .ptrLoad(ptrLoad), .ptrValue(ptrValue),
    .wrByte(wrByte), .wrData(wrData), .rdByteDone(rdByteDone), .rdData(rdData));
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input string n, input logic [10:0] e, input logic [10:0] g);
    num_checks++;
    if (e !== g) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rdChk(input logic [7:0] e);
    logic [7:0] d;
    i_host.rd(d);
    chk("rdData", {3'h0, e}, {3'h0, d});
  endtask
  task automatic outChk(input logic [7:0] p);
    chk("forcedPwm", {10'h0, p[7]}, {10'h0, forcedPwm});
    chk("extClkFollow", {10'h0, p[6]}, {10'h0, extClkFollow});
    chk("syncLocked", {10'h0, p[6] & extClk}, {10'h0, syncLocked});
    chk("voutCode", {5'h0, p[5:0]}, {5'h0, voutCode});
    chk("voutMv", 11'(750 + 10 * p[5:0]), voutMv);
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #300000;
    n_errors++;
    print_verdict();
  end
  initial begin
    {reset_n, clkEn, logicSupplyUvlo, mainSupplyUvlo} = 4'h4;
    {selHi, selLo, extClk} = 3'h1;
    void'($urandom(38724));
    repeat (4) @(posedge clk);
    reset_n <= 1'h1;
    i_host.ptr(8'h01);
    rdChk(8'h1E);
    rdChk(8'hB0);
    for (int i = 0; i < 24; i++) begin
      pOne = (i == 0) ? 8'h00 : 8'($urandom);
      pTwo = (i == 1) ? 8'hFF : 8'($urandom);
      i_host.ptr(8'h01);
      i_host.wr(pOne);
      i_host.wr(pTwo);
      #1 chk("regPointer", 11'h003, {3'h0, regPointer});
      i_host.ptr(8'h01);
      rdChk(pOne);
      rdChk(pTwo);
      rdChk(8'h00);
      extClk <= 1'($urandom);
      {selHi, selLo} <= i[0] ? 2'h2 : 2'h1;
      repeat (4) @(posedge clk);
      #1 outChk(i[0] ? pTwo : pOne);
      @(posedge clk) {selHi, selLo} <= i[1] ? 2'h3 : 2'h0;
      repeat (4) @(posedge clk);
      #1 outChk(i[0] ? pTwo : pOne);
    end
    for (int k = 0; k < 2; k++) begin
      i_host.ptr(8'h01);
      i_host.wr(8'h55);
      i_host.wr(8'hAA);
      @(posedge clk) {logicSupplyUvlo, mainSupplyUvlo} <= 2'($urandom_range(3, 1));
      @(posedge clk) {logicSupplyUvlo, mainSupplyUvlo} <= 2'h0;
      i_host.ptr(8'h01);
      rdChk(8'h1E);
      rdChk(8'hB0);
    end
    i_host.ptr(8'h10);
    nEn = 0;
    for (int k = 0; k < 8; k++) begin
      en = 1'($urandom);
      nEn += en;
      clkEn <= en;
      i_host.rd(junk);
    end
    clkEn <= 1'h1;
    #1 chk("regPointer", 11'(8'h10 + nEn), {3'h0, regPointer});
    print_verdict();
  end
endmodule // vvpr_regs_tb

/* File: verilog/vvpr_pkg.sv */
// Purpose: constants and carriers for the voltage profile register bank
// Assumes: 8-bit register pointer and data from the two-wire bus engine
// Notes: profile one and two only
// Operation
// R1 - selector pins hi low, lo high pick profile one as active.
// R2 - selector pins hi high, lo low pick profile two as active.
// R3 - policy bit 7 clear signals automatic light-load and pwm switching.
// R4 - policy bit 7 set signals forced pwm at every load.
// R5 - sync bit 6 clear means external clock is ignored.
// R6 - sync bit 6 set means lock to external clock when present.
// R7 - bits 5..0 give voltage code, 0.75V plus 10mV per step.
// R8 - profile one powers up 0x1E.
// R9 - profile two powers up 0xB0.
// R10 - sync bit of both profiles powers up clear.
// R11 - either supply lockout restores both profiles to power-up values.
// R12 - each acknowledged write byte loads the pointed register.
// R13 - pointer advances by one after each transferred data byte.
// R14 - pointer 0x01 maps profile one, 0x02 profile two, both read/write.
// R15 - selected profile fields drive continuous control outputs.
package vvpr_pkg;
  localparam logic [7:0] PTR_PROFILE_ONE   = 8'h01;
  localparam logic [7:0] PTR_PROFILE_TWO   = 8'h02;
  localparam logic [7:0] RST_PROFILE_ONE   = 8'h1E;
  localparam logic [7:0] RST_PROFILE_TWO   = 8'hB0;
  localparam int         POS_POLICY        = 7;
  localparam int         POS_SYNC          = 6;
  localparam int         VCODE_MSB         = 5;
  localparam int         VOUT_BASE_MV      = 750;
  localparam int         VOUT_STEP_MV      = 10;
  localparam logic [7:0] READ_UNMAPPED     = 8'h00;

  typedef struct packed {
    logic       forcedPwm;
    logic       extClkFollow;
    logic [5:0] voutCode;
  } vvpr_profile_type;

  typedef struct packed {
    vvpr_profile_type profileOne;
    vvpr_profile_type profileTwo;
    logic [7:0]       pointer;
    logic [7:0]       readData;
    logic             forcedPwm;
    logic             extClkFollow;
    logic             syncLocked;
    logic [5:0]       voutCode;
    logic [10:0]      voutMv;
    logic [1:0]       selHiSync;
    logic [1:0]       selLoSync;
    logic [1:0]       extClkSync;
  } vvpr_state_type;
endpackage

/* File: verilog/vvpr_regs.sv */
// Purpose: two voltage profile registers, selector decode, control outputs
// Assumes: bus engine gives same-clock strobes after ack of each byte
// Notes: selector pins and external clock presence are asynchronous
`timescale 1ns/1ps
module vvpr_regs (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       clkEn,
  // supply lockout indications, same clock
  input  wire logic       logicSupplyUvlo,
  input  wire logic       mainSupplyUvlo,
  // bus engine side
  input  wire logic       ptrLoad,
  input  wire logic [7:0] ptrValue,
  input  wire logic       wrByte,
  input  wire logic [7:0] wrData,
  input  wire logic       rdByteDone,
  output logic      [7:0] rdData,
  output logic      [7:0] regPointer,
  // pins
  input  wire logic       profile_sel_hi_pin,
  input  wire logic       profile_sel_lo_pin,
  input  wire logic       extClkPresent,
  // converter controls
  output logic            forcedPwm,
  output logic            extClkFollow,
  output logic            syncLocked,
  output logic      [5:0] voutCode,
  output logic     [10:0] voutMv
);
  vvpr_pkg::vvpr_state_type st_ff, nxt_st;

  function automatic vvpr_pkg::vvpr_profile_type unpack(input logic [7:0] b);
    unpack.forcedPwm    = b[vvpr_pkg::POS_POLICY];
    unpack.extClkFollow = b[vvpr_pkg::POS_SYNC];
    unpack.voutCode     = b[vvpr_pkg::VCODE_MSB:0];
  endfunction

  always_comb begin
    vvpr_pkg::vvpr_profile_type act;
    act = '0;
    nxt_st = st_ff;
    nxt_st.selHiSync = {st_ff.selHiSync[0], profile_sel_hi_pin};
    nxt_st.selLoSync = {st_ff.selLoSync[0], profile_sel_lo_pin};
    nxt_st.extClkSync = {st_ff.extClkSync[0], extClkPresent};
    if (ptrLoad) begin
      nxt_st.pointer = ptrValue;
    end else if (wrByte || rdByteDone) begin
      nxt_st.pointer = st_ff.pointer + 8'h01; // R13
    end
    if (wrByte) begin
      if (st_ff.pointer == vvpr_pkg::PTR_PROFILE_ONE) begin
        nxt_st.profileOne = unpack(wrData); // R12 R14
      end else if (st_ff.pointer == vvpr_pkg::PTR_PROFILE_TWO) begin
        nxt_st.profileTwo = unpack(wrData); // R12 R14
      end
    end
    // lockout wins over a write in the same cycle
    if (logicSupplyUvlo || mainSupplyUvlo) begin
      nxt_st.profileOne = unpack(vvpr_pkg::RST_PROFILE_ONE); // R11
      nxt_st.profileTwo = unpack(vvpr_pkg::RST_PROFILE_TWO); // R11
    end
    // read data follows the pointer after any update
    if (nxt_st.pointer == vvpr_pkg::PTR_PROFILE_ONE) begin
      nxt_st.readData = nxt_st.profileOne; // R14
    end else if (nxt_st.pointer == vvpr_pkg::PTR_PROFILE_TWO) begin
      nxt_st.readData = nxt_st.profileTwo; // R14
    end else begin
      nxt_st.readData = vvpr_pkg::READ_UNMAPPED;
    end
    // other pin patterns belong to profiles outside this block: hold last
    if (st_ff.selHiSync[1] != st_ff.selLoSync[1]) begin
      act = st_ff.selHiSync[1] ? nxt_st.profileTwo : nxt_st.profileOne; // R1 R2
      nxt_st.forcedPwm    = act.forcedPwm; // R3 R4 R15
      nxt_st.extClkFollow = act.extClkFollow; // R5 R6 R15
      nxt_st.voutCode     = act.voutCode; // R7 R15
      // eleven bits: the top code reaches 1380 mV, ten bits would wrap
      nxt_st.voutMv = 11'(vvpr_pkg::VOUT_BASE_MV)
                    + 11'(act.voutCode) * 11'(vvpr_pkg::VOUT_STEP_MV); // R7
    end
    nxt_st.syncLocked = nxt_st.extClkFollow & st_ff.extClkSync[1]; // R5 R6
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_ff <= '{profileOne: vvpr_pkg::vvpr_profile_type'(vvpr_pkg::RST_PROFILE_ONE),
                 profileTwo: vvpr_pkg::vvpr_profile_type'(vvpr_pkg::RST_PROFILE_TWO),
                 default: '0}; // R8 R9 R10
    end else if (clkEn) begin
      st_ff <= nxt_st;
    end
  end

  assign rdData       = st_ff.readData;
  assign regPointer   = st_ff.pointer;
  assign forcedPwm    = st_ff.forcedPwm;
  assign extClkFollow = st_ff.extClkFollow;
  assign syncLocked   = st_ff.syncLocked;
  assign voutCode     = st_ff.voutCode;
  assign voutMv       = st_ff.voutMv;

  property p_uvlo_restores;
    @(posedge clk) disable iff (!reset_n)
      (clkEn && (logicSupplyUvlo || mainSupplyUvlo)) |=>
        (st_ff.profileOne == 8'h1E && st_ff.profileTwo == 8'hB0);
  endproperty
  a_uvlo_restores: assert property (p_uvlo_restores) else $error("lockout did not restore"); // R11

  property p_write_one;
    @(posedge clk) disable iff (!reset_n)
      (clkEn && wrByte && !ptrLoad && st_ff.pointer == 8'h01 && !logicSupplyUvlo
       && !mainSupplyUvlo) |=> st_ff.profileOne == $past(wrData);
  endproperty
  a_write_one: assert property (p_write_one) else $error("profile one write lost"); // R12

  property p_write_two;
    @(posedge clk) disable iff (!reset_n)
      (clkEn && wrByte && !ptrLoad && st_ff.pointer == 8'h02 && !logicSupplyUvlo
       && !mainSupplyUvlo) |=> st_ff.profileTwo == $past(wrData);
  endproperty
  a_write_two: assert property (p_write_two) else $error("profile two write lost"); // R14

  property p_ptr_inc;
    @(posedge clk) disable iff (!reset_n)
      (clkEn && !ptrLoad && (wrByte || rdByteDone)) |=>
        regPointer == 8'($past(regPointer) + 8'h01);
  endproperty
  a_ptr_inc: assert property (p_ptr_inc) else $error("pointer did not advance"); // R13

  property p_sel_one;
    @(posedge clk) disable iff (!reset_n)
      (clkEn && !st_ff.selHiSync[1] && st_ff.selLoSync[1]) |=>
        {forcedPwm, extClkFollow, voutCode} == st_ff.profileOne;
  endproperty
  a_sel_one: assert property (p_sel_one) else $error("profile one not active"); // R1

  property p_sel_two;
    @(posedge clk) disable iff (!reset_n)
      (clkEn && st_ff.selHiSync[1] && !st_ff.selLoSync[1]) |=>
        {forcedPwm, extClkFollow, voutCode} == st_ff.profileTwo;
  endproperty
  a_sel_two: assert property (p_sel_two) else $error("profile two not active"); // R2

  property p_mv;
    @(posedge clk) disable iff (!reset_n)
      voutMv == 11'h000 || voutMv == 11'h2EE + 11'(voutCode) * 11'h00A;
  endproperty
  a_mv: assert property (p_mv) else $error("voltage decode wrong"); // R7

  property p_sync_off;
    @(posedge clk) disable iff (!reset_n)
      !extClkFollow |-> !syncLocked;
  endproperty
  a_sync_off: assert property (p_sync_off) else $error("clock followed while disabled"); // R5

  property p_policy;
    @(posedge clk) disable iff (!reset_n)
      (clkEn && !st_ff.selHiSync[1] && st_ff.selLoSync[1] && !st_ff.profileOne.forcedPwm)
        |=> !forcedPwm;
  endproperty
  a_policy: assert property (p_policy) else $error("policy bit wrong"); // R3

  // checks below watch registered state and outputs, along with clkEn, the bus strobes and data, and the lockout inputs
  property p_forced_one;
    @(posedge clk) disable iff (!reset_n)
      (clkEn && !st_ff.selHiSync[1] && st_ff.selLoSync[1] && st_ff.profileOne.forcedPwm)
        |=> forcedPwm;
  endproperty
  a_forced_one: assert property (p_forced_one) else $error("forced pwm lost"); // R4

  property p_forced_two;
    @(posedge clk) disable iff (!reset_n)
      (clkEn && st_ff.selHiSync[1] && !st_ff.selLoSync[1] && st_ff.profileTwo.forcedPwm)
        |=> forcedPwm;
  endproperty
  a_forced_two: assert property (p_forced_two) else $error("forced pwm lost"); // R4

  property p_policy_two;
    @(posedge clk) disable iff (!reset_n)
      (clkEn && st_ff.selHiSync[1] && !st_ff.selLoSync[1] && !st_ff.profileTwo.forcedPwm)
        |=> !forcedPwm;
  endproperty
  a_policy_two: assert property (p_policy_two) else $error("policy bit wrong"); // R3

  property p_sync_sel_off;
    @(posedge clk) disable iff (!reset_n)
      (clkEn && !st_ff.selHiSync[1] && st_ff.selLoSync[1] && !st_ff.profileOne.extClkFollow)
        |=> !extClkFollow;
  endproperty
  a_sync_sel_off: assert property (p_sync_sel_off) else $error("sync enable wrong"); // R5

  property p_sync_sel_on;
    @(posedge clk) disable iff (!reset_n)
      (clkEn && !st_ff.selHiSync[1] && st_ff.selLoSync[1] && st_ff.profileOne.extClkFollow)
        |=> extClkFollow;
  endproperty
  a_sync_sel_on: assert property (p_sync_sel_on) else $error("sync enable lost"); // R6

  property p_sync_follow;
    @(posedge clk) disable iff (!reset_n)
      clkEn |=>
        syncLocked == (extClkFollow && $past(st_ff.extClkSync[1]));
  endproperty
  a_sync_follow: assert property (p_sync_follow) else $error("clock lock wrong"); // R6

  property p_hold_other;
    @(posedge clk) disable iff (!reset_n)
      (clkEn && st_ff.selHiSync[1] == st_ff.selLoSync[1]) |=>
        $stable({forcedPwm, extClkFollow, voutCode, voutMv});
  endproperty
  a_hold_other: assert property (p_hold_other) else $error("outputs moved on other pins"); // R15

  property p_mv_two;
    @(posedge clk) disable iff (!reset_n)
      (clkEn && st_ff.selHiSync[1] && !st_ff.selLoSync[1]) |=>
        voutMv == 11'h2EE + 11'(st_ff.profileTwo.voutCode) * 11'h00A;
  endproperty
  a_mv_two: assert property (p_mv_two) else $error("voltage of profile two wrong"); // R7

  property p_vrange;
    @(posedge clk) disable iff (!reset_n)
      voutMv != 11'h000 |->
        (voutMv >= 11'h2EE && voutMv <= 11'h564);
  endproperty
  a_vrange: assert property (p_vrange) else $error("voltage out of range"); // R7

  property p_sync_clear;
    @(posedge clk) disable iff (!reset_n)
      (clkEn && (logicSupplyUvlo || mainSupplyUvlo)) |=>
        (!st_ff.profileOne.extClkFollow && !st_ff.profileTwo.extClkFollow);
  endproperty
  a_sync_clear: assert property (p_sync_clear) else $error("sync bit not cleared"); // R10

  property p_write_old;
    @(posedge clk) disable iff (!reset_n)
      (clkEn && wrByte && ptrLoad && st_ff.pointer == vvpr_pkg::PTR_PROFILE_ONE
       && !logicSupplyUvlo && !mainSupplyUvlo) |=> st_ff.profileOne == $past(wrData);
  endproperty
  a_write_old: assert property (p_write_old) else $error("write with load lost"); // R12

  property p_unmapped_wr;
    @(posedge clk) disable iff (!reset_n)
      (clkEn && wrByte && st_ff.pointer != vvpr_pkg::PTR_PROFILE_ONE
       && st_ff.pointer != vvpr_pkg::PTR_PROFILE_TWO) |=> $stable(st_ff.profileTwo);
  endproperty
  a_unmapped_wr: assert property (p_unmapped_wr) else $error("unmapped write landed"); // R14

  property p_ptr_load;
    @(posedge clk) disable iff (!reset_n)
      (clkEn && ptrLoad) |=>
        regPointer == $past(ptrValue);
  endproperty
  a_ptr_load: assert property (p_ptr_load) else $error("pointer not loaded"); // R14

  property p_ptr_wrap;
    @(posedge clk) disable iff (!reset_n)
      (clkEn && !ptrLoad && rdByteDone && regPointer == 8'hFF) |=>
        regPointer == 8'h00;
  endproperty
  a_ptr_wrap: assert property (p_ptr_wrap) else $error("pointer did not wrap"); // R13

  property p_ptr_hold;
    @(posedge clk) disable iff (!reset_n)
      (clkEn && !ptrLoad && !wrByte && !rdByteDone) |=>
        $stable(regPointer);
  endproperty
  a_ptr_hold: assert property (p_ptr_hold) else $error("pointer moved idle"); // R13

  property p_rd_one;
    @(posedge clk) disable iff (!reset_n)
      regPointer == vvpr_pkg::PTR_PROFILE_ONE |->
        rdData == st_ff.profileOne;
  endproperty
  a_rd_one: assert property (p_rd_one) else $error("read of profile one wrong"); // R14

  property p_rd_two;
    @(posedge clk) disable iff (!reset_n)
      regPointer == vvpr_pkg::PTR_PROFILE_TWO |->
        rdData == st_ff.profileTwo;
  endproperty
  a_rd_two: assert property (p_rd_two) else $error("read of profile two wrong"); // R14

  property p_rd_unmapped;
    @(posedge clk) disable iff (!reset_n)
      (regPointer != vvpr_pkg::PTR_PROFILE_ONE && regPointer != vvpr_pkg::PTR_PROFILE_TWO)
        |-> rdData == vvpr_pkg::READ_UNMAPPED;
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read wrong"); // R14

  property p_freeze_ptr;
    @(posedge clk) disable iff (!reset_n)
      !clkEn |=>
        $stable(regPointer);
  endproperty
  a_freeze_ptr: assert property (p_freeze_ptr) else $error("pointer moved while frozen"); // R13

  property p_freeze_prof;
    @(posedge clk) disable iff (!reset_n)
      !clkEn |=>
        ($stable(st_ff.profileOne) && $stable(st_ff.profileTwo));
  endproperty
  a_freeze_prof: assert property (p_freeze_prof) else $error("profile moved while frozen"); // R12
endmodule // vvpr_regs
